// *** design/tbm_consts.svh ***
// Constants for the 10 Mbps MII control and status block.
// Assumes a 250 MHz clock; definitions only, no logic.
`ifndef TBM_CONSTS_SVH
`define TBM_CONSTS_SVH
// Register indices; the byte address is four times the index.
`define TBM_IDX_BSR 6'h01
`define TBM_IDX_ANX 6'h06
`define TBM_IDX_CFG 6'h10
`define TBM_IDX_ST2 6'h11
`define TBM_BSR_LINK 2
`define TBM_ANX_PGRX 1
`define TBM_ANX_BASE 5
`define TBM_CFG_LOOP 0
`define TBM_CFG_ANEN 1
`define TBM_CFG_ALTNP 2
`define TBM_CFG_PRE 5
`define TBM_CFG_CRSS 7
`define TBM_CFG_HB 9
`define TBM_CFG_JABD 10
`define TBM_CFG_LOVR 14
`define TBM_CFG_RST 16'h0002
`define TBM_CFG_WMASK 16'h46a7
`define TBM_ST2_POL 5
`define TBM_ST2_AND 7
`define TBM_ST2_FDX 9
`define TBM_ST2_LINK 10
`define TBM_ST2_SPD 14
`define TBM_SFD 8'hd5
`define TBM_LP_INV_N 8
`define TBM_EOF_INV_N 4
`define TBM_CLK_NS 4
`define TBM_BIT_NS 100
`define TBM_SQE_BT 5
`define TBM_SQE_CYC ((`TBM_SQE_BT * `TBM_BIT_NS + `TBM_CLK_NS - 1) / `TBM_CLK_NS)
`define TBM_RX_TMO_MS 96
`define TBM_RX_TMO_CYC (`TBM_RX_TMO_MS * 1000000 / `TBM_CLK_NS)
`define TBM_LP_MS 16
`define TBM_LP_CYC (`TBM_LP_MS * 1000000 / `TBM_CLK_NS)
`define TBM_JAB_MS 20
`define TBM_JAB_CYC (`TBM_JAB_MS * 1000000 / `TBM_CLK_NS)
`define TBM_UNJAB_MS 500
`define TBM_UNJAB_CYC (`TBM_UNJAB_MS * 1000000 / `TBM_CLK_NS)
`endif

// *** design/tbm_ctrl.sv ***
// 10 Mbps twisted-pair receive/transmit control with status registers.
// Assumes a line front end that delivers decoded bits and marker strobes,
// and a MAC on the MII side; all inputs are synchronous to aclk.
`timescale 1ns/10ps
`default_nettype none
`include "tbm_consts.svh"

module tbm_ctrl
	import tbm_pkg::*;
#(
	parameter int unsigned LP_CYC = `TBM_LP_CYC,
	parameter int unsigned RX_TMO_CYC = `TBM_RX_TMO_CYC,
	parameter int unsigned JAB_CYC = `TBM_JAB_CYC,
	parameter int unsigned UNJAB_CYC = `TBM_UNJAB_CYC,
	parameter int unsigned SQE_CYC = `TBM_SQE_CYC
) (
	input wire logic aclk, // Block clock.
	input wire logic aresetn, // Synchronous reset, low active.
	input wire tbm_axi_req_t s_axi, // AXI4-Lite request side.
	output tbm_axi_rsp_t s_axi_rsp, // AXI4-Lite answer side.
	input wire logic ln_rx_act, // Line activity start strobe.
	input wire logic ln_rx_bvld, // Decoded bit strobe.
	input wire logic ln_rx_bit, // Decoded bit, raw polarity.
	input wire logic ln_rx_eof, // End-of-frame marker strobe.
	input wire logic ln_rx_lp, // Link pulse strobe.
	input wire logic ln_rx_inv, // Marker or pulse seen inverted.
	input wire logic an_done, // Negotiation finished level.
	input wire logic an_start, // New negotiation started strobe.
	input wire logic an_page, // Page received strobe.
	input wire logic an_base, // Base page received strobe.
	input wire logic res_fdx, // Resolved full duplex.
	input wire logic res_100, // Resolved 100 Mbps.
	input wire logic mii_tx_en, // MAC transmit enable.
	input wire logic mii_tx_stb, // MAC transmit nibble strobe.
	input wire logic [3:0] mii_txd, // MAC transmit nibble.
	output logic [3:0] mii_rxd, // Receive nibble to MAC.
	output logic mii_rx_stb, // Receive nibble strobe.
	output logic mii_rx_dv, // Receive data valid.
	output logic mii_crs, // Carrier sense.
	output logic mii_col, // Heartbeat only; collisions are not flagged.
	output logic ln_tx_en, // Line transmit enable.
	output logic ln_tx_stb, // Line transmit nibble strobe.
	output logic [3:0] ln_txd, // Line transmit nibble.
	output logic ln_lp, // Link pulse request strobe.
	output logic scr_act, // Scrambler active.
	output logic an_restart // Restart negotiation strobe.
);
	// ****************************************
	// Registers and state
	// ****************************************
	localparam logic [15:0] CFG_WM = `TBM_CFG_WMASK;
	localparam logic [7:0] SFD = `TBM_SFD;
	logic [15:0] cfg_r;
	logic aw_got_r;
	logic [7:0] aw_a_r;
	logic w_got_r;
	logic [31:0] w_d_r;
	logic [3:0] w_s_r;
	logic bvalid_r;
	logic [1:0] bresp_r;
	logic rvalid_r;
	logic [31:0] rdata_r;
	logic [1:0] rresp_r;
	logic wr_do;
	logic rd_take;
	logic rd_hit;
	logic [31:0] rd_data;
	logic wr_hit;
	logic [5:0] rd_idx;
	logic link_r;
	logic pol_r;
	logic [2:0] lpc_r;
	logic [1:0] eofc_r;
	logic pg_r;
	logic base_r;
	logic [31:0] tmo_cnt_r;
	logic tmo;
	logic [31:0] lp_cnt_r;
	logic [31:0] jab_cnt_r;
	logic [31:0] unj_cnt_r;
	logic jab_r;
	logic [31:0] sqe_cnt_r;
	logic tx_en_d_r;
	logic tx_ok;
	tbm_rx_st_t rx_st_r;
	logic [7:0] sh_r;
	logic [7:0] sh_nxt;
	logic [2:0] bcnt_r;
	logic crs_r;
	logic dv_r;
	logic [3:0] rxd_r;
	logic rstb_r;
	logic pend_r;
	logic [7:0] pad_w;

	// ****************************************
	// AXI4-Lite slave
	// ****************************************
	assign wr_do = aw_got_r & w_got_r & ~bvalid_r;
	assign rd_take = s_axi.arvalid & ~rvalid_r;
	assign rd_idx = s_axi.araddr[7:2];

	always_comb begin
		s_axi_rsp = '0;
		s_axi_rsp.awready = ~aw_got_r & ~bvalid_r;
		s_axi_rsp.wready = ~w_got_r & ~bvalid_r;
		s_axi_rsp.bvalid = bvalid_r;
		s_axi_rsp.bresp = bresp_r;
		s_axi_rsp.arready = ~rvalid_r;
		s_axi_rsp.rvalid = rvalid_r;
		s_axi_rsp.rdata = rdata_r;
		s_axi_rsp.rresp = rresp_r;
	end

	always_comb begin
		rd_data = 32'h0000_0000;
		rd_hit = 1'b1;
		case (rd_idx)
			`TBM_IDX_BSR: rd_data[`TBM_BSR_LINK] = link_r;
			`TBM_IDX_ANX: begin
				rd_data[`TBM_ANX_PGRX] = pg_r;
				rd_data[`TBM_ANX_BASE] = base_r;
			end
			`TBM_IDX_CFG: rd_data[15:0] = cfg_r;
			`TBM_IDX_ST2: begin
				rd_data[`TBM_ST2_POL] = pol_r;
				rd_data[`TBM_ST2_AND] = an_done;
				rd_data[`TBM_ST2_FDX] = res_fdx;
				rd_data[`TBM_ST2_LINK] = link_r;
				rd_data[`TBM_ST2_SPD] = res_100;
			end
			default: rd_hit = 1'b0;
		endcase
	end

	always_comb begin
		case (aw_a_r[7:2])
			`TBM_IDX_BSR, `TBM_IDX_ANX, `TBM_IDX_CFG, `TBM_IDX_ST2: wr_hit = 1'b1;
			default: wr_hit = 1'b0;
		endcase
	end

	// Address and data are caught in either order; the answer follows both.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_got_r <= 1'b0;
			aw_a_r <= 8'h00;
			w_got_r <= 1'b0;
			w_d_r <= 32'h0000_0000;
			w_s_r <= 4'h0;
			bvalid_r <= 1'b0;
			bresp_r <= 2'h0;
		end else begin
			if (s_axi.awvalid && s_axi_rsp.awready) begin
				aw_got_r <= 1'b1;
				aw_a_r <= s_axi.awaddr;
			end
			if (s_axi.wvalid && s_axi_rsp.wready) begin
				w_got_r <= 1'b1;
				w_d_r <= s_axi.wdata;
				w_s_r <= s_axi.wstrb;
			end
			if (wr_do) begin
				aw_got_r <= 1'b0;
				w_got_r <= 1'b0;
				bvalid_r <= 1'b1;
				bresp_r <= wr_hit ? 2'h0 : 2'h2;
			end else if (bvalid_r && s_axi.bready) begin
				bvalid_r <= 1'b0;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_r <= 1'b0;
			rdata_r <= 32'h0000_0000;
			rresp_r <= 2'h0;
		end else if (rd_take) begin
			rvalid_r <= 1'b1;
			rdata_r <= rd_data;
			rresp_r <= rd_hit ? 2'h0 : 2'h2;
		end else if (rvalid_r && s_axi.rready) begin
			rvalid_r <= 1'b0;
		end
	end

	// Only the configuration word is writable; status writes are ignored.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cfg_r <= `TBM_CFG_RST;
		end else if (wr_do && aw_a_r[7:2] == `TBM_IDX_CFG) begin
			for (int b = 0; b < 2; b++) begin
				if (w_s_r[b]) begin
					cfg_r[8*b+:8] <= w_d_r[8*b+:8] & CFG_WM[8*b+:8];
				end
			end
		end
	end

	// A new page in the same cycle as the read or restart survives.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pg_r <= 1'b0;
			base_r <= 1'b0;
		end else begin
			if (an_page) begin
				pg_r <= 1'b1;
			end else if ((rd_take && rd_idx == `TBM_IDX_ANX)
				|| (cfg_r[`TBM_CFG_ALTNP] && an_start)) begin
				pg_r <= 1'b0;
			end
			if (an_base) begin
				base_r <= 1'b1;
			end else if (rd_take && rd_idx == `TBM_IDX_ANX) begin
				base_r <= 1'b0;
			end
		end
	end

	// ****************************************
	// Link integrity and polarity
	// ****************************************
	assign tmo = (tmo_cnt_r == 32'(RX_TMO_CYC - 1));

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tmo_cnt_r <= 32'h0000_0000;
		end else if (ln_rx_lp || ln_rx_act || ln_rx_bvld || tmo) begin
			tmo_cnt_r <= 32'h0000_0000;
		end else begin
			tmo_cnt_r <= tmo_cnt_r + 32'h0000_0001;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			link_r <= 1'b0;
			an_restart <= 1'b0;
		end else begin
			an_restart <= 1'b0;
			if (ln_rx_lp) begin
				link_r <= 1'b1;
			end else if (tmo && link_r && !cfg_r[`TBM_CFG_LOVR]) begin
				link_r <= 1'b0;
				an_restart <= cfg_r[`TBM_CFG_ANEN];
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pol_r <= 1'b0;
			lpc_r <= 3'h0;
			eofc_r <= 2'h0;
		end else if (tmo) begin
			pol_r <= 1'b0;
			lpc_r <= 3'h0;
			eofc_r <= 2'h0;
		end else begin
			if (ln_rx_lp) begin
				lpc_r <= ln_rx_inv ? lpc_r + 3'h1 : 3'h0;
			end
			if (ln_rx_eof) begin
				eofc_r <= ln_rx_inv ? eofc_r + 2'h1 : 2'h0;
			end
			if ((ln_rx_lp && ln_rx_inv && lpc_r == 3'(`TBM_LP_INV_N - 1))
				|| (ln_rx_eof && ln_rx_inv && eofc_r == 2'(`TBM_EOF_INV_N - 1))) begin
				pol_r <= 1'b1;
			end
		end
	end

	// ****************************************
	// Transmit, link pulses, jabber, heartbeat
	// ****************************************
	assign tx_ok = (link_r | cfg_r[`TBM_CFG_LOVR]) & ~jab_r;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ln_tx_en <= 1'b0;
			ln_tx_stb <= 1'b0;
			ln_txd <= 4'h0;
			scr_act <= 1'b0;
		end else begin
			ln_tx_en <= mii_tx_en & tx_ok & ~cfg_r[`TBM_CFG_LOOP];
			ln_tx_stb <= mii_tx_stb & mii_tx_en & tx_ok & ~cfg_r[`TBM_CFG_LOOP];
			ln_txd <= mii_txd;
			scr_act <= res_100;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			lp_cnt_r <= 32'h0000_0000;
			ln_lp <= 1'b0;
		end else begin
			ln_lp <= 1'b0;
			if (mii_tx_en) begin
				lp_cnt_r <= 32'h0000_0000;
			end else if (lp_cnt_r == 32'(LP_CYC - 1)) begin
				lp_cnt_r <= 32'h0000_0000;
				ln_lp <= 1'b1;
			end else begin
				lp_cnt_r <= lp_cnt_r + 32'h0000_0001;
			end
		end
	end

	// The unjabber wait runs only while the MAC is quiet, so a MAC that keeps
	// transmitting stays locked out.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			jab_r <= 1'b0;
			jab_cnt_r <= 32'h0000_0000;
			unj_cnt_r <= 32'h0000_0000;
		end else if (cfg_r[`TBM_CFG_JABD]) begin
			jab_r <= 1'b0;
			jab_cnt_r <= 32'h0000_0000;
			unj_cnt_r <= 32'h0000_0000;
		end else if (jab_r) begin
			jab_cnt_r <= 32'h0000_0000;
			if (mii_tx_en) begin
				unj_cnt_r <= 32'h0000_0000;
			end else if (unj_cnt_r == 32'(UNJAB_CYC - 1)) begin
				jab_r <= 1'b0;
				unj_cnt_r <= 32'h0000_0000;
			end else begin
				unj_cnt_r <= unj_cnt_r + 32'h0000_0001;
			end
		end else if (mii_tx_en) begin
			if (jab_cnt_r == 32'(JAB_CYC - 1)) begin
				jab_r <= 1'b1;
			end
			jab_cnt_r <= jab_cnt_r + 32'h0000_0001;
		end else begin
			jab_cnt_r <= 32'h0000_0000;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tx_en_d_r <= 1'b0;
			sqe_cnt_r <= 32'h0000_0000;
			mii_col <= 1'b0;
		end else begin
			tx_en_d_r <= mii_tx_en;
			if (tx_en_d_r && !mii_tx_en && cfg_r[`TBM_CFG_HB]) begin
				sqe_cnt_r <= 32'(SQE_CYC);
			end else if (sqe_cnt_r != 32'h0000_0000) begin
				sqe_cnt_r <= sqe_cnt_r - 32'h0000_0001;
			end
			mii_col <= (sqe_cnt_r != 32'h0000_0000);
		end
	end

	// ****************************************
	// Receive framing
	// ****************************************
	// Bits arrive oldest first, so the newest bit enters at the top.
	assign sh_nxt = {ln_rx_bit ^ pol_r, sh_r[7:1]};
	assign pad_w = {4'hf, sh_r[7:4]} >> (3'h4 - bcnt_r);

	// The D nibble of the delimiter goes out the cycle after the 5 nibble;
	// bits are 25 cycles apart, so no data bit can collide with it.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rx_st_r <= rx_idle;
			sh_r <= 8'h00;
			bcnt_r <= 3'h0;
			crs_r <= 1'b0;
			dv_r <= 1'b0;
			rxd_r <= 4'h0;
			rstb_r <= 1'b0;
			pend_r <= 1'b0;
		end else begin
			rstb_r <= 1'b0;
			case (rx_st_r)
				rx_idle: begin
					if (ln_rx_act) begin
						crs_r <= 1'b1;
						dv_r <= cfg_r[`TBM_CFG_PRE];
						sh_r <= 8'h00;
						bcnt_r <= 3'h0;
						rx_st_r <= rx_pre;
					end
				end
				rx_pre: begin
					if (ln_rx_eof) begin
						crs_r <= cfg_r[`TBM_CFG_CRSS];
						bcnt_r <= 3'h0;
						rx_st_r <= rx_tail;
					end else if (ln_rx_bvld) begin
						sh_r <= sh_nxt;
						bcnt_r <= bcnt_r + 3'h1;
						if (sh_nxt == SFD) begin
							rxd_r <= SFD[3:0];
							rstb_r <= 1'b1;
							dv_r <= 1'b1;
							pend_r <= 1'b1;
							bcnt_r <= 3'h0;
							rx_st_r <= rx_data;
						end else if (dv_r && bcnt_r[1:0] == 2'h3) begin
							rxd_r <= sh_nxt[7:4];
							rstb_r <= 1'b1;
						end
					end
				end
				rx_data: begin
					if (pend_r) begin
						rxd_r <= SFD[7:4];
						rstb_r <= 1'b1;
						pend_r <= 1'b0;
					end
					if (ln_rx_eof) begin
						crs_r <= cfg_r[`TBM_CFG_CRSS];
						rx_st_r <= rx_tail;
					end else if (ln_rx_bvld) begin
						sh_r <= sh_nxt;
						bcnt_r <= bcnt_r + 3'h1;
						if (bcnt_r[1:0] == 2'h3) begin
							rxd_r <= sh_nxt[7:4];
							rstb_r <= 1'b1;
						end
					end
				end
				rx_tail: begin
					// Five to seven leftover bits leave the second nibble unsent.
					if (bcnt_r != 3'h0 && bcnt_r < 3'h4) begin
						rxd_r <= pad_w[3:0];
						rstb_r <= 1'b1;
					end
					dv_r <= 1'b0;
					crs_r <= 1'b0;
					pend_r <= 1'b0;
					rx_st_r <= rx_idle;
				end
				default: begin
					rx_st_r <= rx_idle;
				end
			endcase
		end
	end

	// Loopback takes the MII receive side from the MAC's own transmit.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			mii_rxd <= 4'h0;
			mii_rx_stb <= 1'b0;
			mii_rx_dv <= 1'b0;
			mii_crs <= 1'b0;
		end else if (cfg_r[`TBM_CFG_LOOP]) begin
			mii_rxd <= mii_txd;
			mii_rx_stb <= mii_tx_stb & mii_tx_en & ~jab_r;
			mii_rx_dv <= mii_tx_en & ~jab_r;
			mii_crs <= mii_tx_en & ~jab_r;
		end else begin
			mii_rxd <= rxd_r;
			mii_rx_stb <= rstb_r;
			mii_rx_dv <= dv_r;
			mii_crs <= crs_r;
		end
	end
endmodule : tbm_ctrl
`default_nettype wire

// *** design/tbm_pkg.sv ***
// Types for the 10 Mbps MII control and status block.
// Assumes an AXI4-Lite master with 8-bit addresses and 32-bit data.
package tbm_pkg;
	typedef struct packed {
		logic awvalid;
		logic [7:0] awaddr;
		logic wvalid;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bready;
		logic arvalid;
		logic [7:0] araddr;
		logic rready;
	} tbm_axi_req_t;
	typedef struct packed {
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} tbm_axi_rsp_t;
	typedef enum logic [1:0] {
		rx_idle = 2'b00,
		rx_pre = 2'b01,
		rx_data = 2'b10,
		rx_tail = 2'b11
	} tbm_rx_st_t;
endpackage : tbm_pkg

// *** verif/tbm_ctrl_test.sv ***
// Self-checking bench for the 10 Mbps MII control block.
// Assumes shortened counts; expected reads and nibbles are queued.
`timescale 1ns/10ps
`default_nettype none
`include "tbm_consts.svh"
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin fails++; \
	$display("mismatch %s exp %0h got %0h", nm, e, g); end end
// ****************************************
// Bench
// ****************************************
module tbm_ctrl_test import tbm_pkg::*;;
	logic aclk = 0;
	logic aresetn = 0;
	tbm_axi_req_t s_axi = '0;
	tbm_axi_rsp_t s_axi_rsp;
	logic act = 0, bvld = 0, rbit = 0, eof = 0, lp = 0, inv = 0, an_done = 0, an_start = 0;
	logic an_page = 0, an_base = 0, fdx = 0, s100 = 0, go = 0;
	logic [7:0] mlen = 8'h08;
	logic tx_en, tx_stb, busy, rx_stb, rx_dv, crs, col, ltx_en, ltx_stb, ln_lp, an_rs, scr;
	logic [3:0] txd, rxd, ltxd, n4;
	logic [31:0] r32;
	logic [33:0] r34;
	int fails = 0, num_checks = 0, seed = 16527, tx_n = 0, lp_n = 0, rs_n = 0;
	logic [33:0] rdq[$];
	logic [3:0] nq[$];
	always #2 aclk = ~aclk;
	tbm_mac u_mac (.aclk(aclk), .go(go), .len(mlen), .busy(busy), .tx_en(tx_en),
		.tx_stb(tx_stb), .txd(txd));
	tbm_ctrl #(.LP_CYC(50), .RX_TMO_CYC(200), .JAB_CYC(100), .UNJAB_CYC(100)) u_dut (
		.aclk(aclk), .aresetn(aresetn), .s_axi(s_axi), .s_axi_rsp(s_axi_rsp),
		.ln_rx_act(act), .ln_rx_bvld(bvld), .ln_rx_bit(rbit), .ln_rx_eof(eof),
		.ln_rx_lp(lp), .ln_rx_inv(inv), .an_done(an_done), .an_start(an_start),
		.an_page(an_page), .an_base(an_base), .res_fdx(fdx), .res_100(s100),
		.mii_tx_en(tx_en), .mii_tx_stb(tx_stb), .mii_txd(txd), .mii_rxd(rxd),
		.mii_rx_stb(rx_stb), .mii_rx_dv(rx_dv), .mii_crs(crs), .mii_col(col),
		.ln_tx_en(ltx_en), .ln_tx_stb(ltx_stb), .ln_txd(ltxd), .ln_lp(ln_lp),
		.scr_act(scr), .an_restart(an_rs));
	always @(posedge aclk) begin
		if (s_axi_rsp.rvalid && s_axi.rready) begin
			r34 = rdq.pop_front();
			`CHK("read", r34, {s_axi_rsp.rresp, s_axi_rsp.rdata})
		end
		if (rx_stb && nq.size() == 0) `CHK("spare nibble", 1'b0, 1'b1)
		else if (rx_stb) begin
			n4 = nq.pop_front();
			`CHK("rx nibble", n4, rxd)
		end
		if (ltx_stb) tx_n++;
		if (ln_lp) lp_n++;
		if (an_rs) rs_n++;
	end
	task complete_run;
		$display("checks %0d fails %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : complete_run
	task clk(input int n);
		repeat (n) @(posedge aclk);
	endtask : clk
	task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
		logic aw, w;
		aw = 0;
		w = 0;
		s_axi.awvalid <= 1'b1;
		s_axi.awaddr <= a;
		s_axi.wvalid <= 1'b1;
		s_axi.wdata <= d;
		s_axi.wstrb <= 4'hf;
		s_axi.bready <= 1'b1;
		while (!(aw && w)) begin
			@(posedge aclk);
			if (!aw && s_axi_rsp.awready) begin
				aw = 1;
				s_axi.awvalid <= 1'b0;
			end
			if (!w && s_axi_rsp.wready) begin
				w = 1;
				s_axi.wvalid <= 1'b0;
			end
		end
		do @(posedge aclk); while (!s_axi_rsp.bvalid);
		`CHK("bresp", e, s_axi_rsp.bresp)
		s_axi.bready <= 1'b0;
	endtask : wr
	task rd(input logic [7:0] a, input logic [33:0] e);
		rdq.push_back(e);
		s_axi.arvalid <= 1'b1;
		s_axi.araddr <= a;
		s_axi.rready <= 1'b1;
		do @(posedge aclk); while (!s_axi_rsp.arready);
		s_axi.arvalid <= 1'b0;
		do @(posedge aclk); while (!s_axi_rsp.rvalid);
		s_axi.rready <= 1'b0;
	endtask : rd
	function logic [33:0] st2(input logic pol, input logic lnk);
		return {19'h0, s100, 3'h0, lnk, fdx, 1'b0, an_done, 1'b0, pol, 5'h0};
	endfunction : st2
	task lbit(input logic b);
		bvld <= 1'b1;
		rbit <= b;
		clk(1);
		bvld <= 1'b0;
		clk(3);
	endtask : lbit
	task lpul(input logic i);
		lp <= 1'b1;
		inv <= i;
		clk(1);
		lp <= 1'b0;
		inv <= 1'b0;
		clk(3);
	endtask : lpul
	// Preamble and start delimiter are 64 alternating bits ending 1,1.
	task frame(input logic pass, input int n);
		logic [31:0] d;
		d = $random(seed);
		if (pass) repeat (15) nq.push_back(4'h5);
		nq.push_back(4'h5);
		nq.push_back(4'hd);
		for (int i = 0; i < n / 4; i++) nq.push_back(d[4 * i +: 4]);
		if (n % 8 inside {[1:3]}) nq.push_back(d[4 * (n / 4) +: 4] | (4'hf << (n % 4)));
		act <= 1'b1;
		clk(1);
		act <= 1'b0;
		clk(2);
		for (int i = 0; i < 64; i++) lbit(!i[0] || i == 63);
		for (int i = 0; i < n; i++) lbit(d[i]);
		eof <= 1'b1;
		clk(1);
		eof <= 1'b0;
		clk(6);
	endtask : frame
	task send(input int len);
		tx_n = 0;
		mlen <= len[7:0];
		go <= 1'b1;
		clk(1);
		go <= 1'b0;
		clk(1);
		while (busy) clk(1);
		clk(140);
	endtask : send
	initial begin
		clk(12);
		aresetn <= 1'b1;
		clk(1);
		rd(8'h40, 34'h2);
		rd(8'h00, {2'b10, 32'h0});
		wr(8'h00, 32'h0, 2'b10);
		wr(8'h40, 32'hffffffff, 2'b0);
		rd(8'h40, {18'h0, `TBM_CFG_WMASK});
		wr(8'h40, 32'h2, 2'b0);
		frame(0, 16);
		frame(0, 18);
		frame(0, 22);
		wr(8'h40, 32'h22, 2'b0);
		frame(1, 16);
		wr(8'h40, 32'h2, 2'b0);
		send(8);
		`CHK("tx without link", 0, tx_n)
		wr(8'h40, 32'h4002, 2'b0);
		send(8);
		`CHK("tx with override", 8, tx_n)
		wr(8'h40, 32'h3, 2'b0);
		for (int i = 0; i < 8; i++) nq.push_back(i[3:0] ^ 4'ha);
		send(8);
		`CHK("tx in loopback", 0, tx_n)
		wr(8'h40, 32'h202, 2'b0);
		send(8);
		wr(8'h40, 32'h2, 2'b0);
		r32 = $random(seed);
		fdx <= r32[2];
		s100 <= r32[1];
		an_done <= r32[0];
		lpul(0);
		rd(8'h04, 34'h4);
		rd(8'h44, st2(0, 1));
		s100 <= 1'b0;
		send(8);
		`CHK("tx with link", 8, tx_n)
		repeat (8) lpul(1);
		rd(8'h44, st2(1, 1));
		lp_n = 0;
		rs_n = 0;
		clk(250);
		`CHK("idle link pulses", 1'b1, lp_n >= 4)
		`CHK("negotiation restart", 1'b1, rs_n > 0)
		rd(8'h44, st2(0, 0));
		rd(8'h04, 34'h0);
		lpul(0);
		send(40);
		`CHK("jabber cut", 1'b1, tx_n < 40)
		lpul(0);
		send(8);
		`CHK("tx after unjabber", 8, tx_n)
		an_page <= 1'b1;
		an_base <= 1'b1;
		clk(1);
		an_page <= 1'b0;
		an_base <= 1'b0;
		clk(1);
		rd(8'h18, 34'h22);
		rd(8'h18, 34'h0);
		wr(8'h40, 32'h6, 2'b0);
		an_page <= 1'b1;
		clk(1);
		an_page <= 1'b0;
		an_start <= 1'b1;
		clk(1);
		an_start <= 1'b0;
		clk(1);
		rd(8'h18, 34'h0);
		clk(4);
		`CHK("queues drained", 0, rdq.size() + nq.size())
		complete_run;
	end
	initial begin
		clk(20000);
		fails++;
		complete_run;
	end
endmodule : tbm_ctrl_test
`default_nettype wire

// *** verif/tbm_mac.sv ***
// Behavioural MAC that sends nibble frames over the MII transmit side.
// Assumes the bench pulses go for one cycle and waits while busy.
`timescale 1ns/10ps
`default_nettype none
// ****************************************
// MAC model
// ****************************************
module tbm_mac (
	input wire logic aclk, // Clock.
	input wire logic go, // Start a frame.
	input wire logic [7:0] len, // Nibbles to send.
	output logic busy, // Frame under way.
	output logic tx_en, // Transmit enable.
	output logic tx_stb, // Nibble strobe.
	output logic [3:0] txd // Nibble.
);
	initial begin
		busy = 1'b0;
		tx_en = 1'b0;
		tx_stb = 1'b0;
		txd = 4'h0;
		forever begin
			@(posedge aclk);
			if (go) begin
				busy <= 1'b1;
				tx_en <= 1'b1;
				for (int i = 0; i < len; i++) begin
					tx_stb <= 1'b1;
					txd <= i[3:0] ^ 4'ha;
					@(posedge aclk);
					tx_stb <= 1'b0;
					// Between strobes the nibble is inverted so stale data is never reused.
					txd <= ~(i[3:0] ^ 4'ha);
					repeat (3) @(posedge aclk);
				end
				tx_en <= 1'b0;
				busy <= 1'b0;
			end
		end
	end
endmodule : tbm_mac
`default_nettype wire

// *** verif/tbm_props.sv ***
// Concurrent checks on the ports of the 10 Mbps MII control block.
// Assumes it is bound into tbm_ctrl and sees nothing but its ports.
`timescale 1ns/10ps
`default_nettype none
// ****************************************
// Checker
// ****************************************
module tbm_props #(
	parameter int unsigned JAB_CYC = 100,
	parameter int unsigned SQE_CYC = 125
) (
	input wire logic aclk, // Clock.
	input wire logic aresetn, // Reset, low active.
	input wire logic res_100, // Resolved speed.
	input wire logic scr_act, // Scrambler on.
	input wire logic mii_tx_en, // MAC enable.
	input wire logic mii_tx_stb, // MAC strobe.
	input wire logic ln_lp, // Link pulse out.
	input wire logic ln_rx_act, // Line activity.
	input wire logic mii_crs, // Carrier sense.
	input wire logic mii_col, // Heartbeat.
	input wire logic ln_tx_stb, // Line strobe.
	input wire logic ln_tx_en // Line enable.
);
	int unsigned col_n;
	int unsigned ten_n;
	// Run lengths are too long for repetition, so they are counted here.
	always_ff @(posedge aclk) begin
		col_n <= mii_col ? col_n + 1 : 0;
		ten_n <= mii_tx_en ? ten_n + 1 : 0;
	end
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	sequence hb_run_s;
		mii_col [*8];
	endsequence
	scr_off_a: assert property (!res_100 [*2] |-> !scr_act)
		else $error("scrambler active at 10 Mbps");
	lp_quiet_a: assert property (mii_tx_en [*2] |-> !ln_lp)
		else $error("link pulse while transmitting");
	crs_cause_a: assert property ($rose(mii_crs) |-> $past(ln_rx_act, 2) || $past(mii_tx_en))
		else $error("carrier sense without a cause");
	tx_src_a: assert property (ln_tx_stb |-> $past(mii_tx_stb))
		else $error("line nibble without a MAC nibble");
	tx_cut_a: assert property (ten_n > JAB_CYC + 2 |-> !ln_tx_en)
		else $error("transmit not cut by jabber");
	col_len_a: assert property ($fell(mii_col) |-> col_n == SQE_CYC)
		else $error("heartbeat length wrong");
	col_start_a: assert property ($rose(mii_col) |-> !mii_tx_en &&
		($past(mii_tx_en, 2) || $past(mii_tx_en, 3) || $past(mii_tx_en, 4)))
		else $error("heartbeat not after a frame");
	col_hold_a: assert property ($rose(mii_col) |-> hb_run_s)
		else $error("heartbeat too short");
endmodule : tbm_props
bind tbm_ctrl tbm_props #(.JAB_CYC(JAB_CYC), .SQE_CYC(SQE_CYC)) u_props (
	.aclk(aclk), .aresetn(aresetn), .res_100(res_100), .scr_act(scr_act),
	.mii_tx_en(mii_tx_en), .mii_tx_stb(mii_tx_stb), .ln_lp(ln_lp), .ln_rx_act(ln_rx_act),
	.mii_crs(mii_crs), .mii_col(mii_col), .ln_tx_stb(ln_tx_stb), .ln_tx_en(ln_tx_en)
);
`default_nettype wire
